// ==== verilog/lbab_bank.sv ====
// Lower I/O register bank with single-bit set, clear and test access.
`timescale 1ns/1ps

module lbab_bank (
  // Clock and reset
  input  wire logic       CLK_SYS_I,
  input  wire logic       RESETN_I,
  // Processor core access
  input  wire logic [5:0] IO_ADDR_I,
  input  wire logic [7:0] IO_WDATA_I,
  input  wire logic       IO_WE_I,
  input  wire logic       IO_RE_I,
  input  wire logic       SET_SINGLE_BIT_OP_I,
  input  wire logic       CLEAR_SINGLE_BIT_OP_I,
  input  wire logic       SKIP_IF_BIT_SET_OP_I,
  input  wire logic       SKIP_IF_BIT_CLEAR_OP_I,
  input  wire logic [2:0] BIT_SEL_I,
  output logic      [7:0] IO_RDATA_O,
  output logic            IO_RD_VALID_O,
  output logic            SKIP_O,
  output logic            TEST_DONE_O,
  // Peripheral status into the bank
  input  wire logic [7:0] CONV_RESULT_LOW_I,
  input  wire logic [7:0] CONV_RESULT_HIGH_I,
  input  wire logic       CONV_DONE_I,
  input  wire logic       CMP_OUT_I,
  input  wire logic       CMP_EVENT_I,
  input  wire logic [3:0] TIMER1_EVENT_I,
  input  wire logic [2:0] SERIAL_EVENT_I,
  input  wire logic       SERIAL_DC_I,
  input  wire logic [7:0] SERIAL_BUFFER_I,
  input  wire logic [3:0] PORT_B_PINS_I,
  // Register values out to the peripherals
  output logic      [7:0] POWER_REDUCTION_O,
  output logic      [7:0] DIGITAL_INPUT_DISABLE_O,
  output logic      [7:0] CONVERTER_CONTROL_B_O,
  output logic      [7:0] CONVERTER_CONTROL_A_O,
  output logic      [7:0] CONVERTER_CHANNEL_SELECT_O,
  output logic      [7:0] COMPARATOR_CONTROL_STATUS_O,
  output logic      [7:0] TIMER1_FLAGS_O,
  output logic      [7:0] TIMER1_INT_MASK_O,
  output logic      [7:0] SERIAL_IFACE_CONTROL_O,
  output logic      [7:0] SERIAL_IFACE_STATUS_O,
  output logic      [7:0] SERIAL_IFACE_SHIFT_DATA_O,
  output logic      [7:0] PIN_CHANGE_MASK_0_O,
  output logic      [7:0] SCRATCH_0_O,
  output logic      [7:0] SCRATCH_1_O,
  output logic      [7:0] SCRATCH_2_O,
  output logic      [7:0] PORT_B_DIRECTION_O
);

  logic [7:0] reg_q    [lbab_pkg::NUM_REGS];
  logic [7:0] reg_hw   [lbab_pkg::NUM_REGS];
  logic       reg_wr   [lbab_pkg::NUM_REGS];
  logic       reg_bit  [lbab_pkg::NUM_REGS];
  logic       bit_ok;
  logic [7:0] rd_val;
  logic       test_val;
  lbab_pkg::lbab_state_t state;
  lbab_pkg::lbab_state_t next_state;

  // Bit operations above the window are dropped, not turned into byte writes.
  assign bit_ok = (IO_ADDR_I <= lbab_pkg::BIT_ACCESS_LAST);

  always_comb begin
    for (int k = 0; k < lbab_pkg::NUM_REGS; k++) begin
      reg_wr[k]  = IO_WE_I && (IO_ADDR_I == lbab_pkg::REG_ADDR[k]);
      reg_bit[k] = bit_ok && (IO_ADDR_I == lbab_pkg::REG_ADDR[k]);
      reg_hw[k]  = 8'h00;
    end
    reg_hw[lbab_pkg::IDX_CONV_CTRL_A][lbab_pkg::CONV_FLAG_BIT]    = CONV_DONE_I;
    reg_hw[lbab_pkg::IDX_CMP_CTRL_STATUS][lbab_pkg::CMP_FLAG_BIT] = CMP_EVENT_I;
    reg_hw[lbab_pkg::IDX_TIMER1_FLAGS] = {2'b00, TIMER1_EVENT_I[3], 2'b00, TIMER1_EVENT_I[2:0]};
    reg_hw[lbab_pkg::IDX_SERIAL_STATUS] = {SERIAL_EVENT_I, 5'b0_0000};
  end

  for (genvar g = 0; g < lbab_pkg::NUM_REGS; g++) begin : g_reg
    lbab_reg8 #(
      .WR_MASK  (lbab_pkg::REG_WR_MASK[g]),
      .W1C_MASK (lbab_pkg::REG_W1C_MASK[g])
    ) u_reg (
      .clk_i    (CLK_SYS_I),
      .rst_n_i  (RESETN_I),
      .wr_i     (reg_wr[g]),
      .set_i    (SET_SINGLE_BIT_OP_I & reg_bit[g]),
      .clr_i    (CLEAR_SINGLE_BIT_OP_I & reg_bit[g]),
      .sel_i    (BIT_SEL_I),
      .wdata_i  (IO_WDATA_I),
      .hw_set_i (reg_hw[g]),
      .q_o      (reg_q[g])
    );
  end

  // Read value; unused addresses and reserved bits read as zero.
  always_comb begin
    rd_val = 8'h00;
    if (IO_ADDR_I == lbab_pkg::ADDR_CONV_RESULT_LOW) begin
      rd_val = CONV_RESULT_LOW_I;
    end else if (IO_ADDR_I == lbab_pkg::ADDR_CONV_RESULT_HIGH) begin
      rd_val = CONV_RESULT_HIGH_I;
    end else if (IO_ADDR_I == lbab_pkg::ADDR_SERIAL_BUFFER) begin
      rd_val = SERIAL_BUFFER_I;
    end else if (IO_ADDR_I == lbab_pkg::ADDR_PORT_B_PINS) begin
      rd_val = {4'h0, PORT_B_PINS_I};
    end else begin
      for (int k = 0; k < lbab_pkg::NUM_REGS; k++) begin
        if (IO_ADDR_I == lbab_pkg::REG_ADDR[k]) begin
          rd_val = reg_q[k] & lbab_pkg::REG_WR_MASK[k];
        end
      end
      if (IO_ADDR_I == lbab_pkg::REG_ADDR[lbab_pkg::IDX_CMP_CTRL_STATUS]) begin
        rd_val[lbab_pkg::CMP_OUT_BIT] = CMP_OUT_I;
      end
      if (IO_ADDR_I == lbab_pkg::REG_ADDR[lbab_pkg::IDX_SERIAL_STATUS]) begin
        rd_val[lbab_pkg::SERIAL_DC_BIT] = SERIAL_DC_I;
      end
    end
  end

  assign test_val = rd_val[BIT_SEL_I];

  always_comb begin
    next_state           = state;
    next_state.rd_valid  = IO_RE_I;
    next_state.test_done = 1'b0;
    next_state.skip      = 1'b0;
    if (IO_RE_I) begin
      next_state.rdata = rd_val;
    end
    // The skip answer follows one cycle after the test request.
    if ((SKIP_IF_BIT_SET_OP_I || SKIP_IF_BIT_CLEAR_OP_I) && bit_ok) begin
      next_state.test_done = 1'b1;
      next_state.skip      = SKIP_IF_BIT_SET_OP_I ? test_val : ~test_val;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign IO_RDATA_O                  = state.rdata;
  assign IO_RD_VALID_O               = state.rd_valid;
  assign SKIP_O                      = state.skip;
  assign TEST_DONE_O                 = state.test_done;
  assign POWER_REDUCTION_O           = reg_q[lbab_pkg::IDX_POWER_REDUCTION];
  assign DIGITAL_INPUT_DISABLE_O     = reg_q[lbab_pkg::IDX_DIGITAL_IN_DIS];
  assign CONVERTER_CONTROL_B_O       = reg_q[lbab_pkg::IDX_CONV_CTRL_B];
  assign CONVERTER_CONTROL_A_O       = reg_q[lbab_pkg::IDX_CONV_CTRL_A];
  assign CONVERTER_CHANNEL_SELECT_O  = reg_q[lbab_pkg::IDX_CONV_CHAN_SEL];
  assign COMPARATOR_CONTROL_STATUS_O = reg_q[lbab_pkg::IDX_CMP_CTRL_STATUS];
  assign TIMER1_FLAGS_O              = reg_q[lbab_pkg::IDX_TIMER1_FLAGS];
  assign TIMER1_INT_MASK_O           = reg_q[lbab_pkg::IDX_TIMER1_INT_MASK];
  assign SERIAL_IFACE_CONTROL_O      = reg_q[lbab_pkg::IDX_SERIAL_CTRL];
  assign SERIAL_IFACE_STATUS_O       = reg_q[lbab_pkg::IDX_SERIAL_STATUS];
  assign SERIAL_IFACE_SHIFT_DATA_O   = reg_q[lbab_pkg::IDX_SERIAL_SHIFT];
  assign PIN_CHANGE_MASK_0_O         = reg_q[lbab_pkg::IDX_PIN_CHANGE_MASK0];
  assign SCRATCH_0_O                 = reg_q[lbab_pkg::IDX_SCRATCH_0];
  assign SCRATCH_1_O                 = reg_q[lbab_pkg::IDX_SCRATCH_1];
  assign SCRATCH_2_O                 = reg_q[lbab_pkg::IDX_SCRATCH_2];
  assign PORT_B_DIRECTION_O          = reg_q[lbab_pkg::IDX_PORT_B_DIRECTION];

  // Checks. Helper signals hold snapshots so that $past sees plain signals.
  logic       no_t1_event;
  logic       t1_wr;
  logic       t1_bitop;
  logic       s0_set;
  logic       high_bitop;
  logic [7:0] scratch0;
  logic [7:0] timer1;

  assign no_t1_event = (TIMER1_EVENT_I == 4'h0);
  assign t1_wr       = reg_wr[lbab_pkg::IDX_TIMER1_FLAGS];
  assign t1_bitop    = (SET_SINGLE_BIT_OP_I | CLEAR_SINGLE_BIT_OP_I)
                       & reg_bit[lbab_pkg::IDX_TIMER1_FLAGS];
  assign s0_set      = SET_SINGLE_BIT_OP_I & reg_bit[lbab_pkg::IDX_SCRATCH_0] & ~IO_WE_I;
  assign high_bitop  = (SET_SINGLE_BIT_OP_I | CLEAR_SINGLE_BIT_OP_I) & ~bit_ok & ~IO_WE_I;
  assign scratch0    = reg_q[lbab_pkg::IDX_SCRATCH_0];
  assign timer1      = reg_q[lbab_pkg::IDX_TIMER1_FLAGS];

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESETN_I);

  sequence t1_quiet_write_s(logic [7:0] d);
    t1_wr && !t1_bitop && IO_WDATA_I == d && no_t1_event;
  endsequence

  high_bitop_ignored_a: assert property (high_bitop |=> $stable(scratch0) && $stable(timer1))
    else $error("Bit operation above the window changed a register.");

  skip_answer_a: assert property ((SKIP_IF_BIT_SET_OP_I || SKIP_IF_BIT_CLEAR_OP_I) && bit_ok
    |=> TEST_DONE_O && (SKIP_O == ($past(SKIP_IF_BIT_SET_OP_I) ? $past(test_val)
                                                                : !$past(test_val))))
    else $error("Skip answer does not match the tested bit.");

  flag_zero_keeps_a: assert property (t1_quiet_write_s(8'h00) |=> timer1 == $past(timer1))
    else $error("Writing zero changed a timer1 flag.");

  flag_one_clears_a: assert property (t1_quiet_write_s(8'h04)
    |=> timer1 == ($past(timer1) & ~8'h04))
    else $error("Writing one did not clear only that timer1 flag.");

  other_bits_kept_a: assert property (t1_bitop && !t1_wr && no_t1_event
    |=> ((timer1 ^ $past(timer1)) & ~(8'h01 << $past(BIT_SEL_I))) == 8'h00)
    else $error("Single-bit operation disturbed another flag.");

  bit_set_lands_a: assert property (s0_set
    |=> scratch0 == ($past(scratch0) | (8'h01 << $past(BIT_SEL_I))))
    else $error("Single-bit set did not reach the selected bit.");

  read_data_a: assert property (IO_RE_I |=> IO_RD_VALID_O && IO_RDATA_O == $past(rd_val))
    else $error("Read data does not match the addressed register.");

endmodule : lbab_bank

// ==== verilog/lbab_pkg.sv ====
// Package with the address map, field masks and state types of the low I/O bit access bank.
package lbab_pkg;

  localparam int unsigned NUM_REGS = 16;

  // Upper end of the bit-accessible I/O window.
  localparam logic [5:0] BIT_ACCESS_LAST = 6'h1F;

  // Stored registers, by table index.
  localparam int unsigned IDX_POWER_REDUCTION  = 0;
  localparam int unsigned IDX_DIGITAL_IN_DIS   = 1;
  localparam int unsigned IDX_CONV_CTRL_B      = 2;
  localparam int unsigned IDX_CONV_CTRL_A      = 3;
  localparam int unsigned IDX_CONV_CHAN_SEL    = 4;
  localparam int unsigned IDX_CMP_CTRL_STATUS  = 5;
  localparam int unsigned IDX_TIMER1_FLAGS     = 6;
  localparam int unsigned IDX_TIMER1_INT_MASK  = 7;
  localparam int unsigned IDX_SERIAL_CTRL      = 8;
  localparam int unsigned IDX_SERIAL_STATUS    = 9;
  localparam int unsigned IDX_SERIAL_SHIFT     = 10;
  localparam int unsigned IDX_PIN_CHANGE_MASK0 = 11;
  localparam int unsigned IDX_SCRATCH_0        = 12;
  localparam int unsigned IDX_SCRATCH_1        = 13;
  localparam int unsigned IDX_SCRATCH_2        = 14;
  localparam int unsigned IDX_PORT_B_DIRECTION = 15;

  // I/O addresses of the stored registers, in table order.
  localparam logic [5:0] REG_ADDR [NUM_REGS] = '{
    6'h00, 6'h01, 6'h03, 6'h06, 6'h07, 6'h08, 6'h0B, 6'h0C,
    6'h0D, 6'h0E, 6'h0F, 6'h12, 6'h13, 6'h14, 6'h15, 6'h17};

  // Bits that software may change, flag bits included.
  localparam logic [7:0] REG_WR_MASK [NUM_REGS] = '{
    8'h0F, 8'hFF, 8'hD7, 8'hFF, 8'hFF, 8'hDF, 8'h27, 8'h27,
    8'hFF, 8'hEF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F};

  // Status flags set by hardware and cleared by writing a one.
  localparam logic [7:0] REG_W1C_MASK [NUM_REGS] = '{
    8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h10, 8'h27, 8'h00,
    8'h00, 8'hE0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  localparam logic [7:0] REG_RESET_VAL = 8'h00;

  // Registers whose value comes straight from the peripherals.
  localparam logic [5:0] ADDR_CONV_RESULT_LOW  = 6'h04;
  localparam logic [5:0] ADDR_CONV_RESULT_HIGH = 6'h05;
  localparam logic [5:0] ADDR_SERIAL_BUFFER    = 6'h10;
  localparam logic [5:0] ADDR_PORT_B_PINS      = 6'h16;

  // Live level bits merged into the read value, and hardware flag bit positions.
  localparam int unsigned CMP_OUT_BIT     = 5;
  localparam int unsigned SERIAL_DC_BIT   = 4;
  localparam int unsigned CONV_FLAG_BIT   = 4;
  localparam int unsigned CMP_FLAG_BIT    = 4;
  localparam int unsigned SERIAL_FLAG_LSB = 5;

  typedef struct packed {
    logic [7:0] q;
  } lbab_cell_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic       rd_valid;
    logic       skip;
    logic       test_done;
  } lbab_state_t;

endpackage : lbab_pkg

// ==== verilog/lbab_reg8.sv ====
// One 8-bit I/O register with full writes, single-bit writes and write-one-to-clear flags.
`timescale 1ns/1ps

module lbab_reg8 #(
  parameter logic [7:0] WR_MASK  = 8'hFF,
  parameter logic [7:0] W1C_MASK = 8'h00
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Software access
  input  wire logic       wr_i,
  input  wire logic       set_i,
  input  wire logic       clr_i,
  input  wire logic [2:0] sel_i,
  input  wire logic [7:0] wdata_i,
  // Hardware flag events
  input  wire logic [7:0] hw_set_i,
  // Register value
  output logic      [7:0] q_o
);

  lbab_pkg::lbab_cell_t state;
  lbab_pkg::lbab_cell_t next_state;

  always_comb begin
    logic hit;
    logic val;
    hit = 1'b0;
    val = 1'b0;
    next_state = state;
    for (int i = 0; i < 8; i++) begin
      // A single-bit operation touches only the selected bit.
      hit = wr_i | ((set_i | clr_i) & (sel_i == 3'(i)));
      val = wr_i ? wdata_i[i] : set_i;
      if (hit) begin
        if (W1C_MASK[i]) begin
          // Writing one clears a flag, writing zero leaves it.
          if (val) begin
            next_state.q[i] = 1'b0;
          end
        end else if (WR_MASK[i]) begin
          next_state.q[i] = val;
        end
      end
      // An event in the same cycle as its clear still wins.
      if (hw_set_i[i] && W1C_MASK[i]) begin
        next_state.q[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state.q <= lbab_pkg::REG_RESET_VAL;
    end else begin
      state <= next_state;
    end
  end

  assign q_o = state.q;

endmodule : lbab_reg8

// ==== verification/lbab_core_model.sv ====
// Processor core model issuing byte, bit and test accesses to the low I/O bank.
`timescale 1ns/1ps

module lbab_core_model (
  // Clock
  input  wire logic       clk_i,
  // Access requests
  output logic      [5:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            we_o,
  output logic            re_o,
  output logic            set_o,
  output logic            clr_o,
  output logic            tset_o,
  output logic            tclr_o,
  output logic      [2:0] sel_o
);
  initial begin
    {addr_o, wdata_o, we_o, re_o, set_o, clr_o, tset_o, tclr_o, sel_o} = '0;
  end

  function automatic int reg_index(input logic [5:0] a);
    for (int n = 0; n < lbab_pkg::NUM_REGS; n++) begin
      if (lbab_pkg::REG_ADDR[n] == a) begin
        return n;
      end
    end
    return -1;
  endfunction : reg_index

  // Kind 0 write, 1 read, 2 bit set, 3 bit clear, 4 test set, 5 test clear.
  // Released fields are inverted so the bank cannot live on stale values.
  task automatic access(input int kind, input logic [5:0] a, input logic [7:0] d,
                        input logic [2:0] b);
    int r;
    r = reg_index(a);
    if (kind == 0 && r < 0) begin
      return;
    end
    @(posedge clk_i);
    addr_o  <= a;
    sel_o   <= b;
    wdata_o <= (kind == 0) ? (d & lbab_pkg::REG_WR_MASK[r]) : d;
    {we_o, re_o, set_o, clr_o, tset_o, tclr_o} <= 6'b10_0000 >> kind;
    @(posedge clk_i);
    {we_o, re_o, set_o, clr_o, tset_o, tclr_o} <= 6'b00_0000;
    addr_o  <= ~a;
    sel_o   <= ~b;
    wdata_o <= ~d;
    #1;
  endtask : access
endmodule : lbab_core_model

// ==== verification/lbab_bank_test.sv ====
// Self-checking testbench of the low I/O bit access bank.
`timescale 1ns/1ps

`define CHECK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end

module lbab_bank_test;
  logic        clk, rst_n, we, re, setb, clrb, tset, tclr, rdv, skip, done;
  logic [5:0]  addr;
  logic [7:0]  wdata, rdata, conv_lo, conv_hi, ser_buf;
  logic        conv_done, cmp_out, cmp_ev, ser_dc;
  logic [3:0]  t1_ev, pins;
  logic [2:0]  sel, ser_ev;
  logic [7:0]  regs [16];
  logic [7:0]  exp_r [16];
  logic [15:0] lfsr;
  int          n_errors, checks, i, k;

  lbab_core_model i_core (.clk_i(clk), .addr_o(addr), .wdata_o(wdata), .we_o(we), .re_o(re),
    .set_o(setb), .clr_o(clrb), .tset_o(tset), .tclr_o(tclr), .sel_o(sel));

  lbab_bank i_dut (.CLK_SYS_I(clk), .RESETN_I(rst_n), .IO_ADDR_I(addr), .IO_WDATA_I(wdata),
    .IO_WE_I(we), .IO_RE_I(re), .SET_SINGLE_BIT_OP_I(setb), .CLEAR_SINGLE_BIT_OP_I(clrb),
    .SKIP_IF_BIT_SET_OP_I(tset), .SKIP_IF_BIT_CLEAR_OP_I(tclr), .BIT_SEL_I(sel),
    .IO_RDATA_O(rdata), .IO_RD_VALID_O(rdv), .SKIP_O(skip), .TEST_DONE_O(done),
    .CONV_RESULT_LOW_I(conv_lo), .CONV_RESULT_HIGH_I(conv_hi), .CONV_DONE_I(conv_done),
    .CMP_OUT_I(cmp_out), .CMP_EVENT_I(cmp_ev), .TIMER1_EVENT_I(t1_ev),
    .SERIAL_EVENT_I(ser_ev), .SERIAL_DC_I(ser_dc), .SERIAL_BUFFER_I(ser_buf),
    .PORT_B_PINS_I(pins), .POWER_REDUCTION_O(regs[0]), .DIGITAL_INPUT_DISABLE_O(regs[1]),
    .CONVERTER_CONTROL_B_O(regs[2]), .CONVERTER_CONTROL_A_O(regs[3]),
    .CONVERTER_CHANNEL_SELECT_O(regs[4]), .COMPARATOR_CONTROL_STATUS_O(regs[5]),
    .TIMER1_FLAGS_O(regs[6]), .TIMER1_INT_MASK_O(regs[7]), .SERIAL_IFACE_CONTROL_O(regs[8]),
    .SERIAL_IFACE_STATUS_O(regs[9]), .SERIAL_IFACE_SHIFT_DATA_O(regs[10]),
    .PIN_CHANGE_MASK_0_O(regs[11]), .SCRATCH_0_O(regs[12]), .SCRATCH_1_O(regs[13]),
    .SCRATCH_2_O(regs[14]), .PORT_B_DIRECTION_O(regs[15]));

  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nxt

  // Flags only fall where a one is written; other bits take the writable part of the data.
  function automatic logic [7:0] after_wr(input int r, input logic [7:0] old,
                                          input logic [7:0] d);
    return (d & lbab_pkg::REG_WR_MASK[r] & ~lbab_pkg::REG_W1C_MASK[r])
         | (old & lbab_pkg::REG_W1C_MASK[r] & ~d);
  endfunction : after_wr

  task automatic complete_run;
    $display("Errors %0d, checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    complete_run();
  end

  initial begin
    rst_n = 1'b0;
    {conv_lo, conv_hi, ser_buf, conv_done, cmp_out, cmp_ev, ser_dc} = '0;
    {t1_ev, pins, ser_ev} = '0;
    lfsr = 16'h0015;
    n_errors = 0;
    checks = 0;
    for (i = 0; i < 16; i++) exp_r[i] = lbab_pkg::REG_RESET_VAL;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    for (i = 0; i < 16; i++) `CHECK("reset value", exp_r[i], regs[i])
    for (k = 0; k < 40; k++) begin
      lfsr = nxt(lfsr);
      i = lfsr[3:0];
      i_core.access(0, lbab_pkg::REG_ADDR[i], lfsr[15:8], 3'd0);
      exp_r[i] = after_wr(i, exp_r[i], lfsr[15:8]);
      `CHECK("byte write", exp_r[i], regs[i])
      i_core.access(1, lbab_pkg::REG_ADDR[i], 8'h00, 3'd0);
      `CHECK("read back", {1'b1, exp_r[i]}, {rdv, rdata})
    end
    // Walk every bit position of two plain registers with set, test and clear.
    for (k = 0; k < 16; k++) begin
      i = (k < 8) ? 1 : 12;
      i_core.access(2, lbab_pkg::REG_ADDR[i], 8'h00, k[2:0]);
      exp_r[i][k[2:0]] = 1'b1;
      `CHECK("bit set", exp_r[i], regs[i])
      i_core.access(4, lbab_pkg::REG_ADDR[i], 8'h00, k[2:0]);
      `CHECK("skip if set", 2'b11, {done, skip})
      i_core.access(5, lbab_pkg::REG_ADDR[i], 8'h00, k[2:0]);
      `CHECK("skip if clear", 2'b10, {done, skip})
      i_core.access(3, lbab_pkg::REG_ADDR[i], 8'h00, k[2:0]);
      exp_r[i][k[2:0]] = 1'b0;
      `CHECK("bit clear", exp_r[i], regs[i])
    end
    i_core.access(4, 6'h1F, 8'h00, 3'd0);
    `CHECK("last window test", 2'b10, {done, skip})
    // 0x33 folds onto scratch 0 if the upper address bit were dropped.
    i_core.access(exp_r[12][3] ? 3 : 2, 6'h33, 8'h00, 3'd3);
    `CHECK("outside bit op", exp_r[12], regs[12])
    i_core.access(4, 6'h20, 8'h00, 3'd0);
    `CHECK("outside test", 1'b0, done)
    @(posedge clk);
    {t1_ev, ser_ev, cmp_ev, conv_done} <= {4'hF, 3'h7, 1'b1, 1'b1};
    @(posedge clk);
    {t1_ev, ser_ev, cmp_ev, conv_done} <= '0;
    @(posedge clk);
    #1;
    for (i = 0; i < 16; i++) begin
      exp_r[i] = exp_r[i] | lbab_pkg::REG_W1C_MASK[i];
      `CHECK("flag raise", exp_r[i], regs[i])
    end
    i_core.access(2, 6'h0B, 8'h00, 3'd0);
    exp_r[6][0] = 1'b0;
    `CHECK("set op clears flag", exp_r[6], regs[6])
    i_core.access(3, 6'h0B, 8'h00, 3'd1);
    `CHECK("clear op keeps flag", exp_r[6], regs[6])
    for (k = 0; k < 2; k++) begin
      i_core.access(0, 6'h0B, k ? 8'h04 : 8'h00, 3'd0);
      exp_r[6] = after_wr(6, exp_r[6], k ? 8'h04 : 8'h00);
      `CHECK("flag write", exp_r[6], regs[6])
    end
    // An event in the very cycle of its clearing write must still leave the flag set.
    fork
      i_core.access(0, 6'h0B, 8'h01, 3'd0);
      begin
        @(posedge clk);
        t1_ev <= 4'h1;
        @(posedge clk);
        t1_ev <= 4'h0;
      end
    join
    exp_r[6][0] = 1'b1;
    `CHECK("event beats clear", exp_r[6], regs[6])
    i_core.access(2, 6'h0E, 8'h00, 3'd0);
    exp_r[9][0] = 1'b1;
    `CHECK("flags survive set", exp_r[9], regs[9])
    i_core.access(4, 6'h0B, 8'h00, 3'd5);
    `CHECK("flag test", 2'b11, {done, skip})
    @(posedge clk);
    lfsr = nxt(lfsr);
    conv_lo <= lfsr[7:0];
    {conv_hi, ser_buf} <= {lfsr[15:8], ~lfsr[7:0]};
    {pins, cmp_out, ser_dc} <= {lfsr[11:8], 2'b11};
    i_core.access(1, 6'h04, 8'h00, 3'd0);
    `CHECK("result low", lfsr[7:0], rdata)
    i_core.access(1, 6'h05, 8'h00, 3'd0);
    `CHECK("result high", lfsr[15:8], rdata)
    i_core.access(1, 6'h10, 8'h00, 3'd0);
    `CHECK("serial buffer", ~lfsr[7:0], rdata)
    i_core.access(1, 6'h16, 8'h00, 3'd0);
    `CHECK("port b pins", {4'h0, lfsr[11:8]}, rdata)
    // Live level bits show on read while the stored bit stays zero.
    i_core.access(1, 6'h08, 8'h00, 3'd0);
    `CHECK("comparator level", exp_r[5] | 8'h20, rdata)
    i_core.access(1, 6'h0E, 8'h00, 3'd0);
    `CHECK("serial level", exp_r[9] | 8'h10, rdata)
    `CHECK("stored status", exp_r[9], regs[9])
    i_core.access(1, 6'h02, 8'h00, 3'd0);
    `CHECK("unmapped read", 8'h00, rdata)
    complete_run();
  end
endmodule : lbab_bank_test
